/* File: dnm_nco_bank_mixer.sv */
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each sample bypasses or goes through mixing
// - Channel B copies A, own binding, own select
// - Oscillator frequency set by 32-bit tuning word
// - Real sample multiplied by complex exponential
// - Four independent oscillators per channel
// - All accumulators advance even when unselected
// - Hop pin change reaches mixer 36-40 cycles later
// - Source bit picks pins (1) or field (0)
// - Select value picks oscillator in binary order
// - Divider zero gives plain binary frequency mode
// - Software resynchronises after tuning word rewrite
// - Nonzero divider forces exact rational grid
// - Offset left-justified and added to accumulator
// - Resync on link init or armed reference pulse
module dnm_nco_bank_mixer
	import dnm_pkg::*;
(
	input  wire logic                          clock,        // 50 MHz clock
	input  wire logic                          resetn,       // Synchronous reset
	input  wire logic [dnm_pkg::ADDR_W-1:0]    regAddr,      // Register byte address
	input  wire logic [dnm_pkg::DATA_W-1:0]    regWdata,     // Register write data
	input  wire logic                          regWrite,     // Write strobe
	input  wire logic                          regRead,      // Read strobe
	output logic      [dnm_pkg::DATA_W-1:0]    regRdata,     // Read data, next cycle
	input  wire logic [dnm_pkg::SAMPLE_W-1:0]  adcSampleA,   // Converter sample A
	input  wire logic [dnm_pkg::SAMPLE_W-1:0]  adcSampleB,   // Converter sample B
	input  wire logic                          sampleValid,  // Sample pair offered
	output logic                               sampleReady,  // Sample pair accepted
	input  wire logic                          hop_pin_a_bit0,
	input  wire logic                          hop_pin_a_bit1,
	input  wire logic                          hop_pin_b_bit0,
	input  wire logic                          hop_pin_b_bit1,
	input  wire logic                          linkInit,     // Link init done pin
	input  wire logic                          refPulse,     // Timing reference pin
	output logic      [dnm_pkg::OUT_W-1:0]     outIA,        // Channel A in-phase
	output logic      [dnm_pkg::OUT_W-1:0]     outQA,        // Channel A quadrature
	output logic      [dnm_pkg::OUT_W-1:0]     outIB,        // Channel B in-phase
	output logic      [dnm_pkg::OUT_W-1:0]     outQB,        // Channel B quadrature
	output logic                               outValid,     // Output word present
	input  wire logic                          outReady      // Receiver takes word
);
	import dnm_pkg::*;

	localparam int ENTRY_W = 4 * OUT_W;

	// Register state
	logic [CTRL_W-1:0]  ctrl_r, ctrl_nxt;               // Control bits
	logic [RDIV_W-1:0]  rdiv_r, rdiv_nxt;               // rational_step_divider
	dnm_phase_type      freq_r [NUM_CH][NUM_OSC];       // tuning_word_a / tuning_word_b
	dnm_phase_type      freq_nxt [NUM_CH][NUM_OSC];
	logic [OFFS_W-1:0]  offs_r [NUM_CH][NUM_OSC];       // phase_offset_a / phase_offset_b
	logic [OFFS_W-1:0]  offs_nxt [NUM_CH][NUM_OSC];
	logic               armed_r, armed_nxt;             // Next reference pulse armed
	logic [DATA_W-1:0]  rdata_r, rdata_nxt;             // Read data register

	// Pin synchronisers and hop delay line
	logic [5:0]         meta_r, meta_nxt;               // First synchroniser stage
	logic [5:0]         sync_r, sync_nxt;               // Second synchroniser stage
	logic [1:0]         edge_r, edge_nxt;               // Link and reference history
	logic [SEL_W-1:0]   hop_r [NUM_CH][HOP_DELAY];      // Hop select delay line
	logic [SEL_W-1:0]   hop_nxt [NUM_CH][HOP_DELAY];

	// Oscillator state
	dnm_phase_type      acc_r [NUM_CH][NUM_OSC];        // Phase accumulators
	dnm_phase_type      acc_nxt [NUM_CH][NUM_OSC];
	logic [CNT_W-1:0]   cnt_r, cnt_nxt;                 // Rational period counter

	// Output buffer
	logic [ENTRY_W-1:0] head_r, head_nxt;               // Entry seen at the outputs
	logic [ENTRY_W-1:0] tail_r, tail_nxt;               // Second entry
	logic [1:0]         count_r, count_nxt;             // Entries held
	logic               ready_r, ready_nxt;             // Registered ready
	logic               valid_r, valid_nxt;             // Registered output valid

	// Combinational helpers
	logic [SEL_W-1:0]   activeSel [NUM_CH];             // Oscillator in use
	logic [OUT_W-1:0]   mixI [NUM_CH];
	logic [OUT_W-1:0]   mixQ [NUM_CH];
	logic               push, pop, linkRise, refRise, syncFire, rdivWrap;
	logic [CNT_W-1:0]   rdivLimit;

	// Quarter-wave sine lookup over a 6-bit phase
	function automatic logic signed [12:0] sinLut(input logic [LUT_W-1:0] p);
		logic [4:0]         idx;
		logic signed [12:0] mag;
		idx = p[4] ? (5'd16 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
		mag = signed'({1'b0, SIN_TABLE[idx]});
		return p[5] ? -mag : mag;
	endfunction : sinLut

	// Handshake terms and resync sources
	always_comb begin
		push      = sampleValid & ready_r;
		pop       = count_r != 2'd0 && outReady;
		linkRise  = sync_r[4] & ~edge_r[0];
		refRise   = sync_r[5] & ~edge_r[1];
		// Link init resyncs when enabled, otherwise an armed reference pulse does
		syncFire  = ctrl_r[CTRL_SYNC_ILA] ? linkRise : (armed_r & refRise);
		rdivLimit = {rdiv_r, 6'h00};
		rdivWrap  = rdiv_r != RDIV_BASIC && cnt_r == rdivLimit - 1'b1;
	end

	// Oscillator selection per channel
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			// Pins when the source bit is set, register field otherwise
			if (ctrl_r[CTRL_SRC]) begin
				activeSel[c] = hop_r[c][HOP_DELAY-1];
			end else begin
				activeSel[c] = ctrl_r[CTRL_SEL_A + 2*c +: SEL_W];
			end
		end
	end

	// Mixer per channel; plain binary index into the oscillator bank
	for (genvar c = 0; c < NUM_CH; c++) begin : g_mix
		dnm_phase_type             phase;
		logic signed [SAMPLE_W-1:0] x;
		logic signed [12:0]        cosV, sinV;
		logic signed [SAMPLE_W+12:0] pI, pQ;
		always_comb begin
			// Channel B input binding picks its sample source
			x     = (c == 1 && ctrl_r[CTRL_BIND_B]) ? adcSampleB : adcSampleA;
			phase = acc_r[c][activeSel[c]] + {offs_r[c][activeSel[c]], 16'h0000};
			cosV  = sinLut(phase[PHASE_W-1 -: LUT_W] + 6'h10);
			sinV  = sinLut(phase[PHASE_W-1 -: LUT_W]);
			pI    = x * cosV;
			pQ    = x * sinV;
			if (ctrl_r[CTRL_BYPASS]) begin
				mixI[c] = {x, 4'h0};
				mixQ[c] = '0;
			end else begin
				mixI[c] = pI[SAMPLE_W+10 -: OUT_W];
				mixQ[c] = pQ[SAMPLE_W+10 -: OUT_W];
			end
		end
	end

	// Accumulator bank: one adder per oscillator, all running together
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		for (genvar k = 0; k < NUM_OSC; k++) begin : g_osc
			always_comb begin
				if (syncFire) begin
					acc_nxt[c][k] = '0;
				end else if (push && rdivWrap) begin
					acc_nxt[c][k] = '0;
				end else if (push) begin
					acc_nxt[c][k] = acc_r[c][k] + freq_r[c][k];
				end else begin
					acc_nxt[c][k] = acc_r[c][k];
				end
			end
		end
	end

	// Rational period counter, counts samples over 64 times the divider
	always_comb begin
		if (syncFire || rdiv_r == RDIV_BASIC) begin
			cnt_nxt = '0;
		end else if (push) begin
			cnt_nxt = rdivWrap ? '0 : cnt_r + 1'b1;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	// Synchronisers and hop delay line
	always_comb begin
		meta_nxt = {refPulse, linkInit, hop_pin_b_bit1, hop_pin_b_bit0,
			hop_pin_a_bit1, hop_pin_a_bit0};
		sync_nxt = meta_r;
		edge_nxt = sync_r[5:4];
		for (int c = 0; c < NUM_CH; c++) begin
			hop_nxt[c][0] = sync_r[2*c +: SEL_W];
			for (int s = 1; s < HOP_DELAY; s++) begin
				hop_nxt[c][s] = hop_r[c][s-1];
			end
		end
	end

	// Register writes, reads and arming
	always_comb begin
		ctrl_nxt  = ctrl_r;
		rdiv_nxt  = rdiv_r;
		freq_nxt  = freq_r;
		offs_nxt  = offs_r;
		rdata_nxt = '0;
		armed_nxt = armed_r;
		// Armed trigger clears when it fires
		if (syncFire) begin
			armed_nxt = 1'b0;
		end
		if (regWrite) begin
			if (regAddr == REG_CTRL) begin
				ctrl_nxt = regWdata[CTRL_W-1:0];
				// Writing the arm bit from 0 to 1 arms; it wins over a firing
				if (regWdata[CTRL_SYNC_NXT] && !ctrl_r[CTRL_SYNC_NXT]) begin
					armed_nxt = 1'b1;
				end
			end
			if (regAddr == REG_RDIV) begin
				rdiv_nxt = regWdata[RDIV_W-1:0];
			end
			for (int c = 0; c < NUM_CH; c++) begin
				for (int k = 0; k < NUM_OSC; k++) begin
					if (regAddr == REG_FREQ_BASE + 8'(c) * CH_STRIDE + 8'(k) * OSC_STRIDE) begin
						freq_nxt[c][k] = regWdata;
					end
					if (regAddr == REG_PHASE_BASE + 8'(c) * CH_STRIDE + 8'(k) * OSC_STRIDE) begin
						offs_nxt[c][k] = regWdata[OFFS_W-1:0];
					end
				end
			end
		end
		if (regRead) begin
			if (regAddr == REG_CTRL) begin
				rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
			end
			if (regAddr == REG_RDIV) begin
				rdata_nxt = {{(DATA_W-RDIV_W){1'b0}}, rdiv_r};
			end
			if (regAddr == REG_STATUS) begin
				rdata_nxt[STAT_ACT_A +: SEL_W] = activeSel[0];
				rdata_nxt[STAT_ACT_B +: SEL_W] = activeSel[1];
				rdata_nxt[STAT_ARMED]          = armed_r;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				for (int k = 0; k < NUM_OSC; k++) begin
					if (regAddr == REG_FREQ_BASE + 8'(c) * CH_STRIDE + 8'(k) * OSC_STRIDE) begin
						rdata_nxt = freq_r[c][k];
					end
					if (regAddr == REG_PHASE_BASE + 8'(c) * CH_STRIDE + 8'(k) * OSC_STRIDE) begin
						rdata_nxt = {{(DATA_W-OFFS_W){1'b0}}, offs_r[c][k]};
					end
				end
			end
		end
	end

	// Two-entry output buffer; the head entry drives the outputs
	always_comb begin
		logic [ENTRY_W-1:0] entryIn;
		entryIn   = {mixI[0], mixQ[0], mixI[1], mixQ[1]};
		head_nxt  = head_r;
		tail_nxt  = tail_r;
		count_nxt = count_r;
		case (count_r)
			2'd0: begin
				if (push) begin
					head_nxt  = entryIn;
					count_nxt = 2'd1;
				end
			end
			2'd1: begin
				if (push && pop) begin
					head_nxt = entryIn;
				end else if (push) begin
					tail_nxt  = entryIn;
					count_nxt = 2'd2;
				end else if (pop) begin
					count_nxt = 2'd0;
				end
			end
			2'd2: begin
				// Ready is low here, so only a pop can happen
				if (pop) begin
					head_nxt  = tail_r;
					count_nxt = 2'd1;
				end
			end
			default: begin
				count_nxt = 2'd0;
			end
		endcase
		ready_nxt = count_nxt != 2'd2;
		// Valid kept in its own flop so the output comes straight from a register
		valid_nxt = count_nxt != 2'd0;
	end

	// State registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl_r  <= CTRL_RESET;
			rdiv_r  <= RDIV_BASIC;
			freq_r  <= '{default: '0};
			offs_r  <= '{default: '0};
			armed_r <= 1'b0;
			rdata_r <= '0;
			meta_r  <= '0;
			sync_r  <= '0;
			edge_r  <= '0;
			hop_r   <= '{default: '0};
			acc_r   <= '{default: '0};
			cnt_r   <= '0;
			head_r  <= '0;
			tail_r  <= '0;
			count_r <= 2'd0;
			ready_r <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			ctrl_r  <= ctrl_nxt;
			rdiv_r  <= rdiv_nxt;
			freq_r  <= freq_nxt;
			offs_r  <= offs_nxt;
			armed_r <= armed_nxt;
			rdata_r <= rdata_nxt;
			meta_r  <= meta_nxt;
			sync_r  <= sync_nxt;
			edge_r  <= edge_nxt;
			hop_r   <= hop_nxt;
			acc_r   <= acc_nxt;
			cnt_r   <= cnt_nxt;
			head_r  <= head_nxt;
			tail_r  <= tail_nxt;
			count_r <= count_nxt;
			ready_r <= ready_nxt;
			valid_r <= valid_nxt;
		end
	end

	// Outputs from registers
	assign regRdata    = rdata_r;
	assign sampleReady = ready_r;
	assign outValid    = valid_r;
	assign {outIA, outQA, outIB, outQB} = head_r;

	// Checks
	a_acc_runs: assert property (@(posedge clock) disable iff (!resetn)
		push && !syncFire && !rdivWrap |=> acc_r[0][3] == $past(acc_r[0][3]) + $past(freq_r[0][3]))
		else $error("unselected accumulator did not advance");
	a_full_stall: assert property (@(posedge clock) disable iff (!resetn)
		count_r == 2'd2 |-> !sampleReady && outValid)
		else $error("ready high with buffer full");
	a_sel_field: assert property (@(posedge clock) disable iff (!resetn)
		!ctrl_r[CTRL_SRC] |-> activeSel[1] == ctrl_r[CTRL_SEL_B +: SEL_W])
		else $error("field selection not followed");
	a_hop_latency: assert property (@(posedge clock) disable iff (!resetn)
		ctrl_r[CTRL_SRC] |-> activeSel[0] == $past({hop_pin_a_bit1, hop_pin_a_bit0}, 36))
		else $error("hop pins not applied after 36 cycles");
	a_sync_clears: assert property (@(posedge clock) disable iff (!resetn)
		syncFire |=> acc_r[1][2] == '0 && cnt_r == '0)
		else $error("resync did not clear phase");
	a_rdiv_wrap: assert property (@(posedge clock) disable iff (!resetn)
		push && rdivWrap |=> acc_r[0][0] == '0 ##0 cnt_r == '0)
		else $error("rational period did not close");
	a_bypass_word: assert property (@(posedge clock) disable iff (!resetn)
		push && count_r == 2'd0 && ctrl_r[CTRL_BYPASS] && !ctrl_r[CTRL_BIND_B]
		|=> outIA == {$past(adcSampleA), 4'h0} && outQB == '0 && outValid)
		else $error("bypass word wrong");
	a_arm_fire: assert property (@(posedge clock) disable iff (!resetn)
		armed_r && refRise && !ctrl_r[CTRL_SYNC_ILA] && !regWrite |=> !armed_r)
		else $error("armed trigger did not clear");
endmodule : dnm_nco_bank_mixer
`default_nettype wire

/* File: dnm_pkg.sv */
package dnm_pkg;
	// Widths of the datapath
	localparam int SAMPLE_W = 12;                 // Converter sample width
	localparam int OUT_W    = 16;                 // Mixed I or Q word width
	localparam int NUM_CH   = 2;                  // Down-conversion channels
	localparam int NUM_OSC  = 4;                  // Oscillators per channel
	localparam int SEL_W    = 2;                  // Oscillator select width
	localparam int PHASE_W  = 32;                 // Tuning word and accumulator width
	localparam int OFFS_W   = 16;                 // Phase offset width
	localparam int RDIV_W   = 16;                 // Rational divider width
	localparam int LUT_W    = 6;                  // Phase bits used by the sine table
	localparam int ADDR_W   = 8;                  // Register address width
	localparam int DATA_W   = 32;                 // Register data width
	localparam int CNT_W    = RDIV_W + 6;         // Rational sample counter width

	// Register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_RDIV       = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam logic [7:0] REG_FREQ_BASE  = 8'h10; // Channel A 0x10..0x1c, B 0x20..0x2c
	localparam logic [7:0] REG_PHASE_BASE = 8'h30; // Channel A 0x30..0x3c, B 0x40..0x4c
	localparam logic [7:0] CH_STRIDE      = 8'h10;
	localparam logic [7:0] OSC_STRIDE     = 8'h04;

	// Control register fields
	localparam int CTRL_W        = 9;
	localparam int CTRL_BYPASS   = 0;             // Samples skip the mixer
	localparam int CTRL_SRC      = 1;             // select_source_bit
	localparam int CTRL_SEL_A    = 2;             // osc_select_field_a, two bits
	localparam int CTRL_SEL_B    = 4;             // osc_select_field_b, two bits
	localparam int CTRL_BIND_B   = 6;             // chan_b_input_binding
	localparam int CTRL_SYNC_ILA = 7;             // sync_on_link_init
	localparam int CTRL_SYNC_NXT = 8;             // sync_on_next_ref_pulse
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	localparam logic [RDIV_W-1:0] RDIV_BASIC = 16'h0000;

	// Status register fields
	localparam int STAT_ACT_A = 0;
	localparam int STAT_ACT_B = 2;
	localparam int STAT_ARMED = 4;

	// Timing
	localparam int CLOCK_NS    = 20;              // Clock period
	localparam int SYNC_STAGES = 2;               // Pin synchroniser depth
	localparam int HOP_LAT_MIN = 36;              // Pin to mixer latency, cycles
	localparam int HOP_LAT_MAX = 40;
	localparam int HOP_DELAY   = HOP_LAT_MIN - SYNC_STAGES; // Extra pin delay stages
	localparam int RDIV_GRID   = 64;              // Rational grid factor

	// Quarter-wave sine, 17 points, amplitude 2047
	localparam logic [16:0][11:0] SIN_TABLE = {
		12'h7ff, 12'h7f7, 12'h7d9, 12'h7a8, 12'h764, 12'h70e, 12'h6a7, 12'h62f, 12'h5a8,
		12'h513, 12'h472, 12'h3c5, 12'h310, 12'h253, 12'h190, 12'h0c9, 12'h000};

	typedef logic [PHASE_W-1:0] dnm_phase_type;
endpackage : dnm_pkg

/* File: dnm_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module dnm_far_side
	import dnm_pkg::*;
(
	input  wire logic                         clock,       // Block clock
	input  wire logic                         resetn,      // Synchronous reset
	input  wire logic                         stall,       // Receiver holds off
	output var  logic [dnm_pkg::SAMPLE_W-1:0] adcSampleA,  // Converter sample A
	output var  logic [dnm_pkg::SAMPLE_W-1:0] adcSampleB,  // Converter sample B
	output var  logic                         sampleValid, // Pair offered
	input  wire logic                         sampleReady, // Pair accepted
	input  wire logic [dnm_pkg::OUT_W-1:0]    outIA,       // Channel A in-phase
	input  wire logic [dnm_pkg::OUT_W-1:0]    outQA,       // Channel A quadrature
	input  wire logic [dnm_pkg::OUT_W-1:0]    outIB,       // Channel B in-phase
	input  wire logic [dnm_pkg::OUT_W-1:0]    outQB,       // Channel B quadrature
	input  wire logic                         outValid,    // Word present
	output var  logic                         outReady     // Word taken
);
	logic [23:0] srcQ[$]; // Pairs still to offer, A then B
	logic [63:0] gotQ[$]; // Words received, IA QA IB QB

	// Quiet lines at time zero
	initial begin
		sampleValid = 1'b0;
		adcSampleA  = '0;
		adcSampleB  = '0;
		outReady    = 1'b0;
	end

	// Converter side holds a pair until taken; receiver side stalls on request
	always @(posedge clock) begin
		if (resetn && sampleValid && sampleReady) begin
			void'(srcQ.pop_front());
		end
		if (resetn && srcQ.size() != 0) begin
			sampleValid <= 1'b1;
			{adcSampleA, adcSampleB} <= srcQ[0];
		end else begin
			// Idle lines never keep the last value
			sampleValid <= 1'b0;
			{adcSampleA, adcSampleB} <= ~{adcSampleA, adcSampleB};
		end
		if (outValid && outReady) begin
			gotQ.push_back({outIA, outQA, outIB, outQB});
		end
		outReady <= resetn && !stall;
	end
endmodule : dnm_far_side
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dnm_pkg::*;
	logic                clock    = 1'b0; // 50 MHz clock
	logic                resetn   = 1'b0; // Active low reset
	logic [ADDR_W-1:0]   regAddr  = '0;   // Register address
	logic [DATA_W-1:0]   regWdata = '0;   // Register write data
	logic                regWrite = 1'b0; // Write strobe
	logic                regRead  = 1'b0; // Read strobe
	logic [DATA_W-1:0]   regRdata;        // Read data
	logic [SAMPLE_W-1:0] adcSampleA;      // Sample A
	logic [SAMPLE_W-1:0] adcSampleB;      // Sample B
	logic                sampleValid;     // Pair offered
	logic                sampleReady;     // Pair accepted
	logic [1:0]          hopA     = 2'h0; // Hop pins A
	logic [1:0]          hopB     = 2'h0; // Hop pins B
	logic                linkInit = 1'b0; // Link init event
	logic                refPulse = 1'b0; // Reference pulse
	logic [OUT_W-1:0]    outIA, outQA, outIB, outQB;
	logic                outValid;        // Word present
	logic                outReady;        // Word taken
	logic                stall    = 1'b0; // Receiver stall
	int                  fails    = 0;    // Mismatches
	int                  checks   = 0;    // Comparisons

	// Free-running clock
	always #(CLOCK_NS / 2) clock = ~clock;

	dnm_nco_bank_mixer u_dut (.clock(clock), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.adcSampleA(adcSampleA), .adcSampleB(adcSampleB), .sampleValid(sampleValid),
		.sampleReady(sampleReady), .hop_pin_a_bit0(hopA[0]), .hop_pin_a_bit1(hopA[1]),
		.hop_pin_b_bit0(hopB[0]), .hop_pin_b_bit1(hopB[1]), .linkInit(linkInit),
		.refPulse(refPulse), .outIA(outIA), .outQA(outQA), .outIB(outIB), .outQB(outQB),
		.outValid(outValid), .outReady(outReady));

	dnm_far_side u_far (.clock(clock), .resetn(resetn), .stall(stall),
		.adcSampleA(adcSampleA), .adcSampleB(adcSampleB), .sampleValid(sampleValid),
		.sampleReady(sampleReady), .outIA(outIA), .outQA(outQA), .outIB(outIB),
		.outQB(outQB), .outValid(outValid), .outReady(outReady));

	// Verdict and end of run
	task automatic tally_and_finish();
		if (fails == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Compares and counts
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask : chk

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	// One-cycle read, data taken in the following cycle
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 chk(64'(regRdata), 64'(e));
	endtask : rdChk

	// Queues pairs at the converter side
	task automatic send(input int n, input logic [11:0] a, input logic [11:0] b,
		input logic [11:0] inc);
		#1;
		for (int i = 0; i < n; i++) u_far.srcQ.push_back({a + inc * 12'(i), b + inc * 12'(i)});
	endtask : send

	// Bounded wait for received words
	task automatic drain(input int n);
		int i;
		for (i = 0; i < 2000 && u_far.gotQ.size() < n; i++) @(posedge clock);
		if (i == 2000) begin
			fails++;
			tally_and_finish();
		end
	endtask : drain

	// Reset values, readback, narrow field, read-only and unmapped places
	task automatic t_regs();
		logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h30};
		foreach (ra[i]) rdChk(ra[i], 32'h0);
		wr(8'h2c, 32'hdeadbeef);
		rdChk(8'h2c, 32'hdeadbeef);
		wr(8'h4c, 32'h1234abcd);
		rdChk(8'h4c, 32'h0000abcd);
		wr(8'h50, 32'hffffffff);
		rdChk(8'h50, 32'h0);
		wr(REG_STATUS, 32'h1f);
		rdChk(REG_STATUS, 32'h0);
	endtask : t_regs

	// Bypass through a stalled buffer, then channel B binding
	task automatic t_buffer();
		wr(REG_CTRL, 32'h1);
		stall <= 1'b1;
		send(5, 12'h001, 12'h040, 12'h001);
		repeat (12) @(posedge clock);
		#1 chk(64'(sampleReady), 64'h0);
		chk(64'(u_far.srcQ.size()), 64'h3);
		@(posedge clock);
		stall <= 1'b0;
		drain(5);
		for (int i = 0; i < 5; i++) chk(u_far.gotQ[i], {12'(i + 1), 20'h0, 12'(i + 1), 20'h0});
		wr(REG_CTRL, 32'h41);
		send(1, 12'h007, 12'h055, 12'h0);
		drain(6);
		chk(u_far.gotQ[5], {16'h0070, 16'h0, 16'h0550, 16'h0});
		u_far.gotQ.delete();
	endtask : t_buffer

	// Mixing at zero phase and with a half-turn offset on A0 only
	task automatic t_mix();
		wr(REG_CTRL, 32'h0);
		send(1, 12'h064, 12'h0, 12'h0);
		drain(1);
		chk(u_far.gotQ[0], {16'h063f, 16'h0, 16'h063f, 16'h0});
		wr(REG_PHASE_BASE, 32'h8000);
		send(1, 12'h064, 12'h0, 12'h0);
		drain(2);
		chk(u_far.gotQ[1], {16'hf9c0, 16'h0, 16'h063f, 16'h0});
		wr(REG_PHASE_BASE, 32'h0);
		u_far.gotQ.delete();
	endtask : t_mix

	// Oscillators run while unselected; field picks each in turn
	task automatic t_bank();
		logic [31:0] w[4] = '{32'h0, 32'h80000000, 32'h40000000, 32'h80000000};
		logic [31:0] ph;
		for (int s = 0; s < 4; s++) wr(REG_FREQ_BASE + 8'(4 * s), w[s]);
		for (int k = 0; k < 8; k++) begin
			wr(REG_CTRL, 32'(k % 4) << CTRL_SEL_A);
			send(1, 12'h064, 12'h0, 12'h0);
			drain(k + 1);
			ph = w[k % 4] * 32'(k);
			chk(64'(u_far.gotQ[k][63:48]), (ph == 0) ? 64'h063f : 64'hf9c0);
		end
		u_far.gotQ.delete();
	endtask : t_bank

	// Pin selection, ignored source, and hop latency
	task automatic t_hop();
		hopA <= 2'h2;
		hopB <= 2'h3;
		wr(REG_CTRL, 32'h4);
		repeat (45) @(posedge clock);
		rdChk(REG_STATUS, 32'h1);
		wr(REG_CTRL, 32'h6);
		repeat (2) @(posedge clock);
		rdChk(REG_STATUS, 32'he);
		@(posedge clock);
		hopA <= 2'h1;
		repeat (30) @(posedge clock);
		rdChk(REG_STATUS, 32'he);
		repeat (8) @(posedge clock);
		rdChk(REG_STATUS, 32'hd);
	endtask : t_hop

	// Resync, then 65 samples in plain or rational mode
	task automatic t_sync(input logic [15:0] rdiv, input logic useRef, input logic [15:0] expLast);
		wr(REG_RDIV, 32'(rdiv));
		wr(REG_FREQ_BASE, 32'h02000000);
		wr(REG_CTRL, useRef ? 32'h0 : 32'h80);
		if (useRef) begin
			wr(REG_CTRL, 32'h100);
			rdChk(REG_STATUS, 32'h10);
		end
		@(posedge clock);
		if (useRef) refPulse <= 1'b1; else linkInit <= 1'b1;
		repeat (4) @(posedge clock);
		refPulse <= 1'b0;
		linkInit <= 1'b0;
		repeat (6) @(posedge clock);
		rdChk(REG_STATUS, 32'h0);
		send(65, 12'h064, 12'h0, 12'h0);
		drain(65);
		chk(64'(u_far.gotQ[0][63:48]), 64'h063f);
		chk(64'(u_far.gotQ[64][63:48]), 64'(expLast));
		u_far.gotQ.delete();
	endtask : t_sync

	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		t_regs();
		t_buffer();
		t_mix();
		t_bank();
		t_hop();
		t_sync(16'h0000, 1'b0, 16'hf9c0);
		t_sync(16'h0001, 1'b1, 16'h063f);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
